// ### rtl/dio_board.sv
// Purpose: board logic around two parallel/timer chips: decode, interrupter, transceivers
// Assumes: APB register access, jumper and bus pins asynchronous to mclk
// Notes:   chip register space is 64 bytes per chip above the base
//
// Summary of operation
// - every port has its own 8-bit transceiver
// - port C bits steer each port transceiver
// - ports run mode 0 or 1, any submode
// - four handshake lines, four handshake uses
// - handshake line two direction from chip jumper
// - 24-bit timer: periodic, one-shot, square wave
// - timer uses enable, input and output lines
// - remaining port C lines are control only
// - six jumpers pick one of 64 1K bases
// - chip registers forwarded at fixed offsets
// - interrupt on jumper-selected level one to seven
// - four interrupt sources: two ports, two timers
// - five vectors per chip, ten per board
// - A16 odd-byte slave, status/ID interrupter
// - privilege jumper limits to supervisory cycles
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module dio_board import dio_pkg::*; (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             intOut,
    input  wire logic [5:0]  baseAddrJumpers,
    input  wire logic [2:0]  irqLevelJumpers,
    input  wire logic        privilegeSelectJumper,
    input  wire logic        handshakeDirJumperOne,
    input  wire logic        handshakeDirJumperTwo,
    input  wire logic [15:1] vmeAddr,
    input  wire logic [5:0]  vmeAm,
    input  wire logic        vmeAsN,
    input  wire logic        vmeDs0N,
    input  wire logic        vmeIackN,
    input  wire logic        vmeIackInN,
    input  wire logic [3:0]  vmeBgInN,
    output logic      [7:1]  vmeIrqN,
    output logic             vmeIackOutN,
    output logic      [3:0]  vmeBgOutN,
    output logic      [7:0]  vectorOut,
    output logic             vectorOeN,
    output logic      [1:0]  chipSelN,
    output logic      [4:0]  regOffset,
    input  wire logic [1:0]  chipPortIrqN,
    input  wire logic [3:0]  chipPortVecSel,
    input  wire logic [1:0]  timerIn,
    output logic      [1:0]  timerOut,
    input  wire logic [1:0]  handshakeLineTwoIn,
    output logic      [1:0]  handshakeLineTwoOut,
    output logic      [1:0]  handshakeLineTwoOeN,
    input  wire logic [31:0] chipPortData,
    input  wire logic [31:0] fieldIn,
    output logic      [31:0] fieldOut,
    output logic      [31:0] fieldOeN,
    output logic      [31:0] toChipData
);
    typedef struct packed {
        logic [15:0]          ctrl;
        logic [15:0]          mode;
        logic [3:0]           stat;
        logic [3:0]           mask;
        logic [1:0][23:0]     tpre;
        logic [1:0][23:0]     tcnt;
        logic [3:0]           tmode;
        logic [1:0]           tout;
        logic [1:0]           tdone;
        logic [NVEC-1:0][7:0] vec;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
        logic                 intOut;
        logic [7:1]           irqN;
        logic                 iackOutN;
        logic [3:0]           bgOutN;
        logic [7:0]           vecOut;
        logic                 vecOeN;
        logic [1:0]           csN;
        logic [4:0]           regOff;
        logic [1:0]           hsOut;
        logic [1:0]           hsOeN;
        logic [1:0]           hsPrev;
        logic [1:0]           pirqPrev;
    } board_t;
    board_t q, nxt;

    logic [SYNCW-1:0] syncIn, syncOut;
    logic [5:0]  sBase;
    logic [2:0]  sLvl;
    logic        sPriv;
    logic [1:0]  sHsJ;
    logic [15:1] sAddr;
    logic [5:0]  sAm;
    logic        sAsN, sDs0N, sIackN, sIackInN;
    logic [3:0]  sBgN;
    logic [1:0]  sPirqN;
    logic [3:0]  sVsel;
    logic [1:0]  sTin;
    logic [1:0]  sHsIn;

    assign syncIn = {baseAddrJumpers, irqLevelJumpers, privilegeSelectJumper, handshakeDirJumperTwo,
                     handshakeDirJumperOne, vmeAddr, vmeAm, vmeAsN, vmeDs0N, vmeIackN, vmeIackInN,
                     vmeBgInN, chipPortIrqN, chipPortVecSel, timerIn, handshakeLineTwoIn};
    assign {sBase, sLvl, sPriv, sHsJ, sAddr, sAm, sAsN, sDs0N, sIackN, sIackInN,
            sBgN, sPirqN, sVsel, sTin, sHsIn} = syncOut;

    dio_sync #(.W(SYNCW), .RSTV('1)) u_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .d      (syncIn),
        .q      (syncOut)
    );

    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_port
            dio_xcvr u_xcvr (
                .mclk     (mclk),
                .resetn   (resetn),
                .dirOut   (q.ctrl[(gp/2)*CW + (gp%2)]),
                .chipData (chipPortData[gp*8 +: 8]),
                .fieldIn  (fieldIn[gp*8 +: 8]),
                .fieldOut (fieldOut[gp*8 +: 8]),
                .fieldOeN (fieldOeN[gp*8 +: 8]),
                .toChip   (toChipData[gp*8 +: 8])
            );
        end
    endgenerate

    logic        amOk, hit, pending, ours;
    logic [3:0]  ev;
    logic [3:0]  w1c;
    logic        acc, wr;
    logic [1:0]  tRun, tZero;
    logic [3:0]  pend;
    logic [7:0]  vsel;
    logic [11:0] vIdx;

    always_comb begin
        nxt = q;
        ev  = 4'h0;
        w1c = 4'h0;
        // slave decode: short I/O only, odd byte only
        amOk = (sAm == AM_SUP) || (!sPriv && sAm == AM_USR);
        hit  = !sAsN && sIackN && !sDs0N && amOk && (sAddr[15:10] == ~sBase);
        for (int c = 0; c < NCHIP; c++) begin
            nxt.csN[c] = !(hit && (sAddr[CHIP_OFF_BIT] == c[0]));
        end
        nxt.regOff = sAddr[5:1];

        // handshake line two per chip
        for (int c = 0; c < NCHIP; c++) begin
            nxt.hsPrev[c]   = sHsIn[c];
            nxt.pirqPrev[c] = sPirqN[c];
            nxt.hsOeN[c]    = !sHsJ[c];
            if (q.pirqPrev[c] && !sPirqN[c]) begin
                ev[SRC_P0 + c] = 1'b1;
            end
            unique case (hs_mode_t'(q.mode[c*CW +: 2]))
                HS_INTERLOCK: nxt.hsOut[c] = !q.stat[SRC_P0 + c];
                HS_PULSE:     nxt.hsOut[c] = !(ev[SRC_P0 + c]);
                HS_IRQIN: begin
                    nxt.hsOut[c] = 1'b1;
                    if (!sHsJ[c] && q.hsPrev[c] && !sHsIn[c]) begin
                        ev[SRC_P0 + c] = 1'b1;
                    end
                end
                HS_GPIO:      nxt.hsOut[c] = q.ctrl[c*CW + B_HSOUT];
            endcase
        end

        // timers, gated by port C enable and timer input
        for (int c = 0; c < NCHIP; c++) begin
            tZero[c] = (q.tcnt[c] == 24'h000000);
            tRun[c]  = q.ctrl[c*CW + B_TIEN] && sTin[c] && !q.tdone[c] &&
                       (tmr_mode_t'(q.tmode[c*2 +: 2]) != TM_OFF);
            if (tRun[c]) begin
                if (tZero[c]) begin
                    nxt.tcnt[c] = q.tpre[c];
                    unique case (tmr_mode_t'(q.tmode[c*2 +: 2]))
                        TM_PERIODIC: ev[SRC_T0 + c] = 1'b1;
                        TM_ONESHOT: begin
                            ev[SRC_T0 + c] = 1'b1;
                            nxt.tdone[c]   = 1'b1;
                        end
                        TM_SQUARE:   nxt.tout[c] = !q.tout[c];
                        TM_OFF:      nxt.tout[c] = q.tout[c];
                    endcase
                end else begin
                    nxt.tcnt[c] = q.tcnt[c] - 24'h000001;
                end
            end
        end

        // register access: one wait state, commit on the edge that sees pready
        acc = psel && penable;
        wr  = acc && q.pready && pwrite;
        nxt.pready = acc && !q.pready;
        vIdx = (paddr - A_VEC0) >> 2;
        if (acc && !q.pready) begin
            nxt.pslverr = 1'b0;
            nxt.prdata  = 32'h00000000;
            unique case (paddr)
                A_CTRL:  nxt.prdata = {16'h0000, q.ctrl};
                A_MODE:  nxt.prdata = {16'h0000, q.mode};
                A_STAT:  nxt.prdata = {28'h0000000, q.stat};
                A_MASK:  nxt.prdata = {28'h0000000, q.mask};
                A_TPRE0: nxt.prdata = {8'h00, q.tpre[0]};
                A_TPRE1: nxt.prdata = {8'h00, q.tpre[1]};
                A_TMODE: nxt.prdata = {26'h0, q.tdone, q.tmode};
                A_JUMP:  nxt.prdata = {16'h0000, sHsIn, sHsJ, sPriv, sLvl, sBase, q.tout};
                default: begin
                    if (paddr >= A_VEC0 && paddr <= A_VECN && paddr[1:0] == 2'b00) begin
                        nxt.prdata = {24'h000000, q.vec[vIdx[3:0]]};
                    end else begin
                        nxt.pslverr = 1'b1;
                    end
                end
            endcase
        end
        if (wr) begin
            unique case (paddr)
                A_CTRL:  nxt.ctrl = pwdata[15:0];
                A_MODE:  nxt.mode = pwdata[15:0];
                A_STAT:  w1c = pwdata[3:0];
                A_MASK:  nxt.mask = pwdata[3:0];
                A_TPRE0: begin
                    nxt.tpre[0]  = pwdata[23:0];
                    nxt.tcnt[0]  = pwdata[23:0];
                    nxt.tdone[0] = 1'b0;
                end
                A_TPRE1: begin
                    nxt.tpre[1]  = pwdata[23:0];
                    nxt.tcnt[1]  = pwdata[23:0];
                    nxt.tdone[1] = 1'b0;
                end
                A_TMODE: nxt.tmode = pwdata[3:0];
                default: begin
                    if (paddr >= A_VEC0 && paddr <= A_VECN && paddr[1:0] == 2'b00) begin
                        nxt.vec[vIdx[3:0]] = pwdata[7:0];
                    end
                end
            endcase
        end

        // sticky status, set wins over clear
        nxt.stat   = (q.stat & ~w1c) | ev;
        nxt.intOut = |(nxt.stat & nxt.mask);
        pend    = q.stat & q.mask;
        pending = |pend;
        nxt.irqN = 7'h7F;
        for (int l = 1; l <= 7; l++) begin
            if (pending && sLvl == l[2:0]) begin
                nxt.irqN[l] = 1'b0;
            end
        end

        // acknowledge: supply vector of lowest-numbered pending source, else pass chain
        ours = pending && (sLvl != 3'h0) && (sAddr[3:1] == sLvl);
        nxt.iackOutN = ours ? 1'b1 : sIackInN;
        nxt.bgOutN   = sBgN;
        vsel = 8'h00;
        for (int s = NSRC - 1; s >= 0; s--) begin
            if (pend[s]) begin
                if (s >= SRC_T0) begin
                    vsel = 8'((s - SRC_T0) * VPC);
                end else begin
                    vsel = 8'(s * VPC + 1) + {6'h00, sVsel[s*2 +: 2]};
                end
            end
        end
        nxt.vecOeN = !(ours && !sAsN && !sIackN && !sIackInN && !sDs0N);
        nxt.vecOut = nxt.vecOeN ? 8'h00 : q.vec[vsel[3:0]];
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q          <= '0;
            q.ctrl     <= CTRL_RST;
            q.mode     <= MODE_RST;
            q.mask     <= MASK_RST;
            q.tmode    <= TMODE_RST;
            q.tpre     <= {2{TPRE_RST}};
            q.tcnt     <= {2{TPRE_RST}};
            q.vec      <= {NVEC{VEC_RST}};
            q.irqN     <= 7'h7F;
            q.iackOutN <= 1'b1;
            q.bgOutN   <= 4'hF;
            q.vecOeN   <= 1'b1;
            q.csN      <= 2'b11;
            q.hsOut    <= 2'b11;
            q.hsOeN    <= 2'b11;
            q.hsPrev   <= 2'b11;
            q.pirqPrev <= 2'b11;
        end else begin
            q <= nxt;
        end
    end

    assign prdata              = q.prdata;
    assign pready              = q.pready;
    assign pslverr             = q.pslverr;
    assign intOut              = q.intOut;
    assign vmeIrqN             = q.irqN;
    assign vmeIackOutN         = q.iackOutN;
    assign vmeBgOutN           = q.bgOutN;
    assign vectorOut           = q.vecOut;
    assign vectorOeN           = q.vecOeN;
    assign chipSelN            = q.csN;
    assign regOffset           = q.regOff;
    assign timerOut            = q.tout;
    assign handshakeLineTwoOut = q.hsOut;
    assign handshakeLineTwoOeN = q.hsOeN;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_am_ignore:
    assert property (!sAsN && sAm != AM_SUP && sAm != AM_USR |=> chipSelN == 2'b11)
        else $error("chip selected on a non short I/O cycle");
    a_priv_only:
    assert property (sPriv && sAm == AM_USR |=> chipSelN == 2'b11)
        else $error("user cycle answered with privilege jumper fitted");
    a_base_hit:
    assert property (hit |=> chipSelN[$past(sAddr[CHIP_OFF_BIT])] == 1'b0)
        else $error("matching base address not forwarded to chip");
    a_odd_only:
    assert property (sDs0N |=> chipSelN == 2'b11 && vectorOeN)
        else $error("answered a cycle without odd byte strobe");
    a_irq_level:
    assert property (pending && sLvl != 3'h0 |=> vmeIrqN[$past(sLvl)] == 1'b0 && $countones(~vmeIrqN) == 1)
        else $error("interrupt not on selected level");
    a_iack_pass:
    assert property (!ours |=> vmeIackOutN == $past(sIackInN) && vmeBgOutN == $past(sBgN))
        else $error("daisy chain not passed while idle");
    a_sticky_set:
    assert property (ev != 4'h0 |=> (q.stat & $past(ev)) == $past(ev))
        else $error("event lost from status");
    a_timer_reload:
    assert property (tRun[0] && tZero[0] |=> q.tcnt[0] == q.tpre[0])
        else $error("timer did not reload on expiry");
    a_xcvr_dir:
    assert property ($stable(q.ctrl[B_XDIRA]) [*2] |-> fieldOeN[7:0] == {8{~q.ctrl[B_XDIRA]}})
        else $error("port transceiver direction not from control");
    a_hs_dir:
    assert property (resetn |=> handshakeLineTwoOeN == ~$past(sHsJ))
        else $error("handshake line two direction not from jumper");
endmodule

// ### rtl/dio_pkg.sv
// Purpose: shared constants and types for the dual parallel I/O board logic
// Assumes: APB register map chosen for this block, 40 MHz mclk
// Notes:   chip 0 owns ports 0 and 1, chip 1 owns ports 2 and 3
package dio_pkg;
    localparam int NCHIP = 2;
    localparam int NPORT = 4;
    localparam int NSRC  = 4;
    localparam int NVEC  = 10;
    localparam int VPC   = 5;
    localparam int SYNCW = 51;
    localparam int MCLK_HZ = 40_000_000;

    localparam logic [11:0] A_CTRL  = 12'h000;
    localparam logic [11:0] A_MODE  = 12'h004;
    localparam logic [11:0] A_STAT  = 12'h008;
    localparam logic [11:0] A_MASK  = 12'h00C;
    localparam logic [11:0] A_TPRE0 = 12'h010;
    localparam logic [11:0] A_TPRE1 = 12'h014;
    localparam logic [11:0] A_TMODE = 12'h018;
    localparam logic [11:0] A_JUMP  = 12'h01C;
    localparam logic [11:0] A_VEC0  = 12'h020;
    localparam logic [11:0] A_VECN  = 12'h044;

    localparam int B_XDIRA = 0;
    localparam int B_XDIRB = 1;
    localparam int B_TIEN  = 2;
    localparam int B_HSOUT = 3;
    localparam int CW      = 8;
    localparam int CHIP_OFF_BIT = 6;

    localparam int SRC_P0 = 0;
    localparam int SRC_P1 = 1;
    localparam int SRC_T0 = 2;
    localparam int SRC_T1 = 3;

    localparam logic [5:0]  AM_SUP    = 6'h2D;
    localparam logic [5:0]  AM_USR    = 6'h29;
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    localparam logic [15:0] MODE_RST  = 16'h0000;
    localparam logic [3:0]  MASK_RST  = 4'h0;
    localparam logic [3:0]  TMODE_RST = 4'h0;
    localparam logic [23:0] TPRE_RST  = 24'hFFFFFF;
    localparam logic [7:0]  VEC_RST   = 8'h0F;

    typedef enum logic [1:0] {HS_INTERLOCK, HS_PULSE, HS_IRQIN, HS_GPIO} hs_mode_t;
    typedef enum logic [1:0] {TM_OFF, TM_PERIODIC, TM_ONESHOT, TM_SQUARE} tmr_mode_t;
endpackage

// ### rtl/dio_sync.sv
// Purpose: three-stage synchroniser, a bit changes once stages two and three agree
// Assumes: inputs asynchronous to mclk
// Notes:   stage one feeds stage two only
`timescale 1ns/100ps
module dio_sync #(
    parameter int             W    = 8,
    parameter logic [W-1:0]   RSTV = '1
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_t;
    sync_t st_ff, nxt_st;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < W; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.q[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= {4{RSTV}};
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign q = st_ff.q;
endmodule

// ### rtl/dio_xcvr.sv
// Purpose: one 8-bit bidirectional port transceiver
// Assumes: dirOut high drives the field side from the chip side
// Notes:   one direction for all eight lines
`timescale 1ns/100ps
module dio_xcvr (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       dirOut,
    input  wire logic [7:0] chipData,
    input  wire logic [7:0] fieldIn,
    output logic      [7:0] fieldOut,
    output logic      [7:0] fieldOeN,
    output logic      [7:0] toChip
);
    typedef struct packed {
        logic [7:0] fout;
        logic [7:0] oeN;
        logic [7:0] tchip;
    } xcvr_t;
    xcvr_t      st_ff, nxt_st;
    logic [7:0] fieldSync;

    dio_sync #(.W(8), .RSTV(8'h00)) u_fsync (
        .mclk   (mclk),
        .resetn (resetn),
        .d      (fieldIn),
        .q      (fieldSync)
    );

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.oeN   = {8{~dirOut}};
        nxt_st.fout  = dirOut ? chipData : 8'h00;
        nxt_st.tchip = dirOut ? chipData : fieldSync;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '{fout: 8'h00, oeN: 8'hFF, tchip: 8'h00};
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign fieldOut = st_ff.fout;
    assign fieldOeN = st_ff.oeN;
    assign toChip   = st_ff.tchip;
endmodule

// ### tb/vme_dual_parallel_io_bench.sv
// Purpose: self-checking bench for the dual parallel I/O board logic
// Assumes: APB answers with one wait state, bus pins seen about 4 cycles late
// Notes:   decode cases run from a table, the rest are hand-written
`timescale 1ns/100ps
module vme_dual_parallel_io_bench;
    import dio_pkg::*;
    typedef struct {logic [5:0] jmp; logic priv; logic [15:0] a; logic [5:0] am; logic [1:0] cs;} row_t;
    logic        mclk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, chipPortData = 32'h0000003C, fieldIn = 32'h0000C300;
    logic [5:0]  baseAddrJumpers = 6'h3F;
    logic [2:0]  irqLevelJumpers = 3'h5;
    logic        privilegeSelectJumper = 1'h1, handshakeDirJumperOne = 1'h0, handshakeDirJumperTwo = 1'h1;
    logic [3:0]  vmeBgInN = 4'hF, chipPortVecSel = 4'h0;
    logic [1:0]  chipPortIrqN = 2'h3, timerIn = 2'h0, handshakeLineTwoIn = 2'h3;
    logic [31:0] prdata, fieldOut, fieldOeN, toChipData, rd;
    logic        pready, pslverr, intOut, vmeAsN, vmeDs0N, vmeIackN, vmeIackInN, vmeIackOutN, vectorOeN, er;
    logic [15:1] vmeAddr;
    logic [7:1]  vmeIrqN;
    logic [5:0]  vmeAm;
    logic [3:0]  vmeBgOutN;
    logic [7:0]  vectorOut;
    logic [1:0]  chipSelN, timerOut, handshakeLineTwoOut, handshakeLineTwoOeN;
    logic [4:0]  regOffset;
    int          n_errors = 0, num_checks = 0;
    row_t        rows [6] = '{
        '{6'h3E, 1'h1, 16'h040B, AM_SUP, 2'h2}, '{6'h00, 1'h1, 16'hFC41, AM_SUP, 2'h1},
        '{6'h3E, 1'h1, 16'h0801, AM_SUP, 2'h3}, '{6'h3E, 1'h1, 16'h0401, AM_USR, 2'h3},
        '{6'h3E, 1'h0, 16'h0401, AM_USR, 2'h2}, '{6'h3E, 1'h0, 16'h0401, 6'h39, 2'h3}};

    always #12.5 mclk = ~mclk;

    vme_host_model host_u (.mclk, .vmeAddr, .vmeAm, .vmeAsN, .vmeDs0N, .vmeIackN, .vmeIackInN);
    dio_board dut_u (.mclk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .intOut, .baseAddrJumpers, .irqLevelJumpers, .privilegeSelectJumper, .handshakeDirJumperOne,
        .handshakeDirJumperTwo, .vmeAddr, .vmeAm, .vmeAsN, .vmeDs0N, .vmeIackN, .vmeIackInN, .vmeBgInN,
        .vmeIrqN, .vmeIackOutN, .vmeBgOutN, .vectorOut, .vectorOeN, .chipSelN, .regOffset, .chipPortIrqN,
        .chipPortVecSel, .timerIn, .timerOut, .handshakeLineTwoIn, .handshakeLineTwoOut,
        .handshakeLineTwoOeN, .chipPortData, .fieldIn, .fieldOut, .fieldOeN, .toChipData);

    task automatic conclude();
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // setup, access, hold until pready sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (k >= 20) begin
            n_errors++;
            conclude();
        end else begin
            rd = prdata;
            er = pslverr;
            {psel, penable} <= 2'h0;
        end
    endtask

    initial begin
        tick(12);
        check("irq lines", {25'h0, vmeIrqN}, 32'h7F);
        check("selects", {30'h0, chipSelN}, 32'h3);
        check("field oe", fieldOeN, 32'hFFFFFFFF);
        check("vector oe", {31'h0, vectorOeN}, 32'h1);
        resetn <= 1'h1;
        foreach (rows[i]) begin
            baseAddrJumpers       <= rows[i].jmp;
            privilegeSelectJumper <= rows[i].priv;
            tick(6);
            host_u.start(rows[i].a, rows[i].am, 1'h0);
            tick(8);
            check("select", {30'h0, chipSelN}, {30'h0, rows[i].cs});
            if (rows[i].cs != 2'h3) check("offset", {27'h0, regOffset}, {27'h0, rows[i].a[5:1]});
            host_u.stop();
            tick(8);
            check("idle select", {30'h0, chipSelN}, 32'h3);
        end
        vmeBgInN <= 4'h5;
        host_u.start(16'h000B, AM_SUP, 1'h1);
        tick(8);
        check("grant chain", {28'h0, vmeBgOutN}, 32'h5);
        check("ack chain idle", {31'h0, vmeIackOutN}, 32'h0);
        host_u.stop();
        apb(1'h1, 12'h100, 32'h1);
        check("unmapped err", {31'h0, er}, 32'h1);
        apb(1'h0, 12'h100, 32'h0);
        check("unmapped data", rd, 32'h0);
        apb(1'h1, A_VEC0 + 12'h004, 32'hA5);
        apb(1'h1, A_MASK, 32'h1);
        apb(1'h0, A_MASK, 32'h0);
        check("mask", rd, 32'h1);
        chipPortIrqN <= 2'h2;
        tick(8);
        apb(1'h0, A_STAT, 32'h0);
        check("status", rd, 32'h1);
        check("int", {31'h0, intOut}, 32'h1);
        check("irq level", {25'h0, vmeIrqN}, 32'h6F);
        host_u.start(16'h000B, AM_SUP, 1'h1);
        tick(8);
        check("vector oe", {31'h0, vectorOeN}, 32'h0);
        check("vector", {24'h0, vectorOut}, 32'hA5);
        check("ack chain held", {31'h0, vmeIackOutN}, 32'h1);
        host_u.stop();
        chipPortIrqN <= 2'h3;
        apb(1'h1, A_MASK, 32'h0);
        tick(2);
        check("masked int", {31'h0, intOut}, 32'h0);
        apb(1'h1, A_MASK, 32'h1);
        apb(1'h1, A_STAT, 32'h1);
        apb(1'h0, A_STAT, 32'h0);
        check("cleared", rd, 32'h0);
        tick(2);
        check("int clear", {31'h0, intOut}, 32'h0);
        // port direction set before transceiver drives
        apb(1'h1, A_CTRL, 32'h0001);
        tick(4);
        check("port0 oe", {24'h0, fieldOeN[7:0]}, 32'h0);
        check("port0 out", {24'h0, fieldOut[7:0]}, 32'h3C);
        check("port1 oe", {24'h0, fieldOeN[15:8]}, 32'hFF);
        tick(6);
        check("port1 in", {24'h0, toChipData[15:8]}, 32'hC3);
        // both chips line two in GPIO mode, driven only on chip 1 (jumper in), chip 0 timer enabled
        apb(1'h1, A_MODE, 32'h0303);
        apb(1'h1, A_CTRL, 32'h000D);
        tick(2);
        check("hs gpio", {30'h0, handshakeLineTwoOut}, 32'h1);
        check("hs oe", {30'h0, handshakeLineTwoOeN}, 32'h1);
        apb(1'h0, A_MODE, 32'h0);
        check("mode", rd, 32'h0303);
        // chip 0 line two as interrupt input, jumper out
        apb(1'h1, A_MODE, 32'h0002);
        handshakeLineTwoIn <= 2'h2;
        tick(8);
        apb(1'h0, A_STAT, 32'h0);
        check("hs irq in", rd, 32'h1);
        apb(1'h1, A_STAT, 32'h1);
        // periodic timer, held while timer input low
        apb(1'h1, A_TPRE0, 32'h3);
        apb(1'h1, A_TMODE, 32'h1);
        tick(8);
        apb(1'h0, A_STAT, 32'h0);
        check("timer gated", rd, 32'h0);
        timerIn <= 2'h1;
        tick(12);
        apb(1'h0, A_STAT, 32'h0);
        check("timer event", rd, 32'h4);
        apb(1'h1, A_TMODE, 32'h3);
        tick(2);
        er = timerOut[0];
        tick(4);
        check("square wave", {31'h0, timerOut[0]}, {31'h0, ~er});
        conclude();
    end
endmodule

// ### tb/vme_host_model.sv
// Purpose: bus master stand-in driving the board's asynchronous bus pins
// Assumes: board samples these pins through its own synchronisers
// Notes:   released address and modifier lines show the inverse of the last value
`timescale 1ns/100ps
module vme_host_model (
    input  wire logic        mclk,
    output logic      [15:1] vmeAddr,
    output logic      [5:0]  vmeAm,
    output logic             vmeAsN,
    output logic             vmeDs0N,
    output logic             vmeIackN,
    output logic             vmeIackInN
);
    initial begin
        {vmeAddr, vmeAm, vmeAsN, vmeDs0N, vmeIackN, vmeIackInN} = {15'h0000, 6'h00, 4'hF};
    end

    // odd-byte strobe only, short addressing
    task automatic start(input logic [15:0] a, input logic [5:0] am, input logic iack);
        @(posedge mclk);
        vmeAddr    <= a[15:1];
        vmeAm      <= am;
        vmeIackN   <= ~iack;
        vmeIackInN <= ~iack;
        vmeAsN     <= 1'h0;
        vmeDs0N    <= 1'h0;
    endtask

    task automatic stop();
        @(posedge mclk);
        {vmeAsN, vmeDs0N, vmeIackN, vmeIackInN} <= 4'hF;
        vmeAddr <= ~vmeAddr;
        vmeAm   <= ~vmeAm;
    endtask
endmodule
